// >>> upsw_ctrl.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 2G variant refuses DTR-controlled setting 3
// - setting 3 allowed with any flow control
// - DTR OFF disables port immediately
// - outgoing data or data call re-enables port
// - DTR rising enables, active after 20 ms
// - DTR ON keeps port enabled, no idle
// - DTR call-control function still applied
// - CTS shows port ready (wake delay over) with flow control
// - armed TXD rising edge wakes port
// - wake character discarded until 20 ms
// - wake arming per variant and setting
// - HSPA drops host data in listed cases
// - inactivity timeout disables port again
// - no control to switch wake off
// - extra pre-prefix char is wake when idle
// - dummy command is wake when idle
// - HSPA USB link forces device active
// - multiplexer only on main serial port
// - multiplexer channel set per variant
// - setting 0 never idles, CTS ON
// - timeout 40..65000 frames, char restarts
module upsw_ctrl #(
  parameter bit HSPA      = 1'b1,
  parameter bit REDUCED   = 1'b0,
  parameter int WAKE_CYC  = upsw_pkg::UPSW_WAKE_CYC,
  parameter int FRAME_CYC = upsw_pkg::UPSW_FRAME_CYC
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host lines and module activity
  input  wire logic        dtr_on,
  input  wire logic        rts_on,
  input  wire logic        txd,
  input  wire logic        rx_char,
  input  wire logic        tx_pending,
  input  wire logic        data_call,
  input  wire logic        usb_active,
  output logic             cts_n,
  output logic             port_en,
  output logic             rx_ready,
  output logic             rx_char_ok,
  output logic             host_drop,
  output logic             dev_active,
  output logic             dtr_off_evt,
  output logic             mux_main_en,
  output logic [7:0]       mux_chan_mask
);
  import upsw_pkg::*;
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic       dtr_s;
  logic       rts_s;
  logic       txd_s;
  logic       dtr_rise;
  logic       dtr_fall;
  logic       txd_rise;
  // Two flops per line, then edge memory
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 3'h4; // TXD idles high, no false edge
      sync2_q <= 3'h4;
      prev_q  <= 3'h4;
    end else if (ce) begin
      sync1_q <= {txd, rts_on, dtr_on};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  // Edge detection on synchronised copies
  assign dtr_s    = sync2_q[0];
  assign rts_s    = sync2_q[1];
  assign txd_s    = sync2_q[2];
  assign dtr_rise = dtr_s & ~prev_q[0];
  assign dtr_fall = ~dtr_s & prev_q[0];
  assign txd_rise = txd_s & ~prev_q[2];
  // ==========================================================
  // Register file
  // ==========================================================
  logic [1:0]  mode_q;
  logic        flow_q;
  logic        abd_q;
  logic        mux_q;
  logic [15:0] tmo_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_tmo;
  logic        wr_hit;
  logic [1:0]  wr_mode;
  logic        mode_ok;
  logic [15:0] tmo_in;
  logic [15:0] tmo_clip;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  // Handshakes stall while ce is low; aw and w in any order
  assign s_axi_awready = ce & ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid  = ce & bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid  = ce & rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  // Write decode
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_ctrl  = do_write & (awaddr_q == UPSW_CTRL_OFF);
  assign wr_tmo   = do_write & (awaddr_q == UPSW_TMO_OFF);
  assign wr_hit   = (awaddr_q == UPSW_CTRL_OFF) |
                    (awaddr_q == UPSW_TMO_OFF) |
                    (awaddr_q == UPSW_STAT_OFF);
  assign wr_mode  = wdata_q[UPSW_MODE_LSB +: 2];
  // Setting 3 only on HSPA; flow control does not matter
  assign mode_ok  = HSPA | (wr_mode != UPSW_PS_DTR);
  assign tmo_in   = {wstrb_q[1] ? wdata_q[15:8] : tmo_q[15:8],
                     wstrb_q[0] ? wdata_q[7:0]  : tmo_q[7:0]};
  assign tmo_clip = (tmo_in < UPSW_TMO_MIN) ? UPSW_TMO_MIN :
                    (tmo_in > UPSW_TMO_MAX) ? UPSW_TMO_MAX :
                    tmo_in;
  // Write channel state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= UPSW_RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? UPSW_RESP_OK : UPSW_RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // Control and timeout registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= UPSW_MODE_RST;
      flow_q <= 1'b0;
      abd_q  <= 1'b0;
      mux_q  <= 1'b0;
      tmo_q  <= UPSW_TMO_RST;
    end else if (ce) begin
      if (wr_ctrl && wstrb_q[0]) begin
        if (mode_ok) begin
          mode_q <= wr_mode;
        end
        flow_q <= wdata_q[UPSW_FLOW_BIT];
        abd_q  <= wdata_q[UPSW_ABD_BIT];
        mux_q  <= wdata_q[UPSW_MUX_BIT];
      end
      if (wr_tmo) begin
        tmo_q <= tmo_clip;
      end
    end
  end
  // ==========================================================
  // Power-saving decisions
  // ==========================================================
  upsw_state_t st_q;
  upsw_state_t st_d;
  logic [18:0] wake_cnt_q;
  logic [16:0] frame_cnt_q;
  logic [15:0] inact_q;
  logic        frame_tick;
  logic        m_off;
  logic        m_cyc;
  logic        m_rts;
  logic        m_dtr;
  logic        armed;
  logic        wake_evt;
  logic        hold;
  logic        want;
  logic        busy;
  assign m_off = (mode_q == UPSW_PS_OFF);
  assign m_cyc = (mode_q == UPSW_PS_CYC);
  assign m_rts = (mode_q == UPSW_PS_RTS);
  assign m_dtr = (mode_q == UPSW_PS_DTR);
  assign busy  = tx_pending | data_call;
  // Wake arming while its setting holds, the port is off and flow control is off
  assign armed = ~port_en & ~flow_q &
                 (m_cyc | (~HSPA & m_rts & ~rts_s));
  // First TXD rising edge of any armed char is the wake char
  assign wake_evt = armed & txd_rise;
  assign host_drop = HSPA & ((m_rts & ~flow_q & ~rts_s) |
                             (m_dtr & ~dtr_s));
  // Inactivity hold only in wake-capable settings
  assign hold = (inact_q != 16'h0000) &
                (m_cyc | (~HSPA & m_rts));
  assign want = m_off | busy | hold |
                (m_dtr & dtr_s) |
                (m_rts & rts_s);
  // Char accepted once ready, unless host data is dropped
  assign rx_char_ok = rx_char & rx_ready & ~host_drop;
  assign frame_tick = (frame_cnt_q == 17'(FRAME_CYC - 1));
  // Frame period prescaler
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_q <= 17'h00000;
    end else if (ce) begin
      frame_cnt_q <= frame_tick ? 17'h00000 : frame_cnt_q + 17'h00001;
    end
  end
  // Inactivity timer in frames; a char wins over a clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      inact_q <= 16'h0000;
    end else if (ce) begin
      if (wake_evt || rx_char_ok) begin
        inact_q <= tmo_q;
      end else if (wr_ctrl) begin
        inact_q <= 16'h0000;
      end else if (frame_tick && inact_q != 16'h0000) begin
        inact_q <= inact_q - 16'h0001;
      end
    end
  end
  // Port state: off, waking for 20 ms, on
  always_comb begin
    st_d = st_q;
    case (st_q)
      UPSW_ST_OFF: begin
        if (want) begin
          st_d = UPSW_ST_WAKE;
        end
      end
      UPSW_ST_WAKE: begin
        if (!want) begin
          st_d = UPSW_ST_OFF;
        end else if (wake_cnt_q == 19'h00000) begin
          st_d = UPSW_ST_ON;
        end
      end
      UPSW_ST_ON: begin
        if (!want) begin
          st_d = UPSW_ST_OFF;
        end
      end
      default: begin
        st_d = UPSW_ST_OFF;
      end
    endcase
  end
  // State and wake delay counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q       <= UPSW_ST_OFF;
      wake_cnt_q <= 19'h00000;
    end else if (ce) begin
      st_q <= st_d;
      if (st_q != UPSW_ST_WAKE) begin
        wake_cnt_q <= 19'(WAKE_CYC - 1);
      end else if (wake_cnt_q != 19'h00000) begin
        wake_cnt_q <= wake_cnt_q - 19'h00001;
      end
    end
  end
  // ==========================================================
  // Outputs
  // ==========================================================
  logic dtr_evt_q;
  assign port_en  = (st_q != UPSW_ST_OFF);
  assign rx_ready = (st_q == UPSW_ST_ON);
  // On HSPA, USB link keeps device awake, port still gated
  assign dev_active = rx_ready | (HSPA & usb_active);
  // CTS tracks port with flow control, else held on
  assign cts_n  = flow_q ? ~(m_off | rx_ready) : 1'b0;
  assign mux_main_en = mux_q;
  assign mux_chan_mask = HSPA ? UPSW_MUX_FULL :
                         REDUCED ? UPSW_MUX_RED :
                         UPSW_MUX_NOSA;
  assign dtr_off_evt = dtr_evt_q;
  // DTR drop forwarded to call control in every setting
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dtr_evt_q <= 1'b0;
    end else if (ce) begin
      dtr_evt_q <= dtr_fall;
    end
  end
  // Read data words
  assign ctrl_word = {27'h0, mux_q, abd_q, flow_q, mode_q};
  assign stat_word = {24'h0, dtr_rise, rts_s, dtr_s,
                      host_drop, armed, dev_active,
                      rx_ready, port_en};
  assign rd_hit = (s_axi_araddr[7:2] == UPSW_CTRL_OFF[7:2]) |
                  (s_axi_araddr[7:2] == UPSW_TMO_OFF[7:2]) |
                  (s_axi_araddr[7:2] == UPSW_STAT_OFF[7:2]);
  assign rd_word =
    (s_axi_araddr[7:2] == UPSW_CTRL_OFF[7:2]) ? ctrl_word :
    (s_axi_araddr[7:2] == UPSW_TMO_OFF[7:2])  ? {16'h0, tmo_q} :
    (s_axi_araddr[7:2] == UPSW_STAT_OFF[7:2]) ? stat_word :
    32'h0000_0000;
  // Read channel
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= UPSW_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? UPSW_RESP_OK : UPSW_RESP_ERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> upsw_pkg.sv
package upsw_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] UPSW_CTRL_OFF = 8'h00;
  localparam logic [7:0] UPSW_TMO_OFF  = 8'h04;
  localparam logic [7:0] UPSW_STAT_OFF = 8'h08;

  // Control field positions
  localparam int UPSW_MODE_LSB = 0;
  localparam int UPSW_FLOW_BIT = 2;
  localparam int UPSW_ABD_BIT  = 3;
  localparam int UPSW_MUX_BIT  = 4;

  // Values after reset and timeout limits
  localparam logic [1:0]  UPSW_MODE_RST = 2'h0;
  localparam logic [15:0] UPSW_TMO_RST  = 16'h07D0;
  localparam logic [15:0] UPSW_TMO_MIN  = 16'h0028;
  localparam logic [15:0] UPSW_TMO_MAX  = 16'hFDE8;

  // Power-saving settings
  localparam logic [1:0] UPSW_PS_OFF  = 2'h0;
  localparam logic [1:0] UPSW_PS_CYC  = 2'h1;
  localparam logic [1:0] UPSW_PS_RTS  = 2'h2;
  localparam logic [1:0] UPSW_PS_DTR  = 2'h3;

  // Multiplexer channel sets
  localparam logic [7:0] UPSW_MUX_FULL = 8'hFF;
  localparam logic [7:0] UPSW_MUX_NOSA = 8'h7F;
  localparam logic [7:0] UPSW_MUX_RED  = 8'h07;

  // AXI responses
  localparam logic [1:0] UPSW_RESP_OK  = 2'h0;
  localparam logic [1:0] UPSW_RESP_ERR = 2'h2;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int UPSW_CLK_NS   = 40;
  localparam int UPSW_WAKE_NS  = 20000000;
  localparam int UPSW_FRAME_NS = 4615000;
  localparam int UPSW_WAKE_CYC = UPSW_WAKE_NS / UPSW_CLK_NS;
  localparam int UPSW_FRAME_CYC = UPSW_FRAME_NS / UPSW_CLK_NS;

  // Port state machine
  typedef enum logic [2:0] {
    UPSW_ST_OFF  = 3'b001,
    UPSW_ST_WAKE = 3'b010,
    UPSW_ST_ON   = 3'b100
  } upsw_state_t;

endpackage

// >>> upsw_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker
module upsw_asserts
  import upsw_pkg::*;
#(
  parameter bit HSPA     = 1'b1,
  parameter bit REDUCED  = 1'b0,
  parameter int WAKE_CYC = 20
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       rx_char,
  input wire logic       rx_ready,
  input wire logic       rx_char_ok,
  input wire logic       port_en,
  input wire logic       dev_active,
  input wire logic       usb_active,
  input wire logic       dtr_on,
  input wire logic       dtr_off_evt,
  input wire logic       data_call,
  input wire logic       tx_pending,
  input wire logic       host_drop,
  input wire logic [7:0] mux_chan_mask
);
  int wcnt_q;
  // Cycles spent enabled but not yet ready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) wcnt_q <= 0;
    else if (port_en && !rx_ready) wcnt_q <= wcnt_q + 1;
    else wcnt_q <= 0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_wake;
    $rose(rx_ready) |-> wcnt_q >= WAKE_CYC && wcnt_q <= WAKE_CYC + 1;
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay wrong");
  property p_ok;
    rx_char_ok == (rx_char && rx_ready && !host_drop);
  endproperty
  a_ok: assert property (p_ok) else $error("char accept wrong");
  property p_rdy;
    rx_ready |-> port_en;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready with port off");
  property p_dev;
    dev_active == (rx_ready || (HSPA && usb_active));
  endproperty
  a_dev: assert property (p_dev) else $error("active flag wrong");
  property p_fall;
    $fell(dtr_on) |-> ##[1:5] dtr_off_evt;
  endproperty
  a_fall: assert property (p_fall) else $error("no dtr off event");
  property p_pulse;
    dtr_off_evt |=> !dtr_off_evt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("event too long");
  property p_call;
    (data_call || tx_pending) [*3] |-> port_en;
  endproperty
  a_call: assert property (p_call) else $error("port not enabled");
  property p_drop;
    host_drop |-> !rx_char_ok;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped data taken");
  property p_mask;
    mux_chan_mask == (HSPA ? UPSW_MUX_FULL :
                      (REDUCED ? UPSW_MUX_RED : UPSW_MUX_NOSA));
  endproperty
  a_mask: assert property (p_mask) else $error("channel set wrong");
endmodule
bind upsw_ctrl upsw_asserts #(.HSPA(HSPA), .REDUCED(REDUCED),
  .WAKE_CYC(WAKE_CYC)) u_upsw_asserts (.mclk(mclk), .resetn(resetn),
  .rx_char(rx_char), .rx_ready(rx_ready), .rx_char_ok(rx_char_ok),
  .port_en(port_en), .dev_active(dev_active), .usb_active(usb_active),
  .dtr_on(dtr_on), .dtr_off_evt(dtr_off_evt), .data_call(data_call),
  .tx_pending(tx_pending), .host_drop(host_drop),
  .mux_chan_mask(mux_chan_mask));
`default_nettype wire

// >>> upsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host terminal model
module upsw_host_model #(
  parameter int WAKE_CYC = 20
) (
  input  wire logic mclk,
  input  wire logic in_call,
  output logic      dtr_on,
  output logic      rts_on,
  output logic      txd
);
  // Lines ON, data line idles high
  initial begin
    dtr_on = 1'b1;
    rts_on = 1'b1;
    txd = 1'b1;
  end
  // Control levels change just after an edge
  task automatic set_dtr(input logic v);
    @(posedge mclk);
    dtr_on <= v;
  endtask
  task automatic set_rts(input logic v);
    @(posedge mclk);
    rts_on <= v;
  endtask
  // One frame: start low, LSB first, stop high
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      txd <= f[i];
    end
  endtask
  // Leading dummy wakes the port, real char waits out wake time
  task automatic send_line(input logic [7:0] c);
    if (!in_call) begin
      send_char(8'h55);
      repeat (WAKE_CYC + 8) @(posedge mclk);
    end
    send_char(c);
  endtask
endmodule
`default_nettype wire

// >>> test_uart_power_save_wake_control.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench top
module test_uart_power_save_wake_control;
  import upsw_pkg::*;
  localparam int WK = 20;
  logic        mclk, resetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, mask;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, rx_char, txd;
  logic        tx_pending, data_call, usb_active, dtr_on, rts_on, cts_n;
  logic        port_en, rx_ready, rx_char_ok, host_drop, dev_active;
  logic        dtr_off_evt, mux_main_en;
  int          fail_count, checks;
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  upsw_ctrl #(.WAKE_CYC(WK), .FRAME_CYC(10)) u_upsw_ctrl (
    .mclk(mclk), .resetn(resetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dtr_on(dtr_on),
    .rts_on(rts_on), .txd(txd), .rx_char(rx_char), .tx_pending(tx_pending),
    .data_call(data_call), .usb_active(usb_active), .cts_n(cts_n),
    .port_en(port_en), .rx_ready(rx_ready), .rx_char_ok(rx_char_ok),
    .host_drop(host_drop), .dev_active(dev_active),
    .dtr_off_evt(dtr_off_evt), .mux_main_en(mux_main_en),
    .mux_chan_mask(mask));
  upsw_host_model #(.WAKE_CYC(WK)) u_upsw_host_model (.mclk(mclk),
    .in_call(data_call), .dtr_on(dtr_on), .rts_on(rts_on), .txd(txd));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    wt(WK + 4);
    chk("cts_n", cts_n, 0);
    chk("rx_ready", rx_ready, 1);
    chk("mask", mask, UPSW_MUX_FULL);
    axi_rd(UPSW_CTRL_OFF);
    chk("ctrl", rd, 0);
    axi_rd(UPSW_TMO_OFF);
    chk("tmo", rd, {16'h0000, UPSW_TMO_RST});
    axi_rd(8'h0C);
    chk("rresp", rs, UPSW_RESP_ERR);
    axi_wr(8'h0C, 32'h1, 4'hF);
    chk("bresp", rs, UPSW_RESP_ERR);
    axi_wr(UPSW_CTRL_OFF, 32'h10, 4'hF);
    chk("mux_en", mux_main_en, 1);
    $display("done reset");
  endtask
  task automatic t_tmo;
    axi_wr(UPSW_TMO_OFF, 32'h1, 4'hF);
    axi_rd(UPSW_TMO_OFF);
    chk("tmo_lo", rd, 32'h28);
    axi_wr(UPSW_TMO_OFF, 32'hFFFF, 4'hF);
    axi_rd(UPSW_TMO_OFF);
    chk("tmo_hi", rd, 32'hFDE8);
    axi_wr(UPSW_TMO_OFF, 32'h128, 4'h1);
    axi_rd(UPSW_TMO_OFF);
    chk("tmo_strb", rd, 32'hFD28);
    axi_wr(UPSW_TMO_OFF, 32'h28, 4'hF);
    $display("done timeout");
  endtask
  task automatic t_dtr;
    axi_wr(UPSW_CTRL_OFF, 32'h7, 4'hF);
    u_upsw_host_model.set_dtr(1'b0);
    wt(6);
    chk("port_en", port_en, 0);
    chk("cts_n", cts_n, 1);
    chk("drop", host_drop, 1);
    for (int i = 0; i < 2; i++) begin
      {data_call, tx_pending} <= 2'b01 << i;
      wt(4);
      chk("port_en", port_en, 1);
      {data_call, tx_pending} <= 2'b00;
      wt(4);
      chk("port_en", port_en, 0);
    end
    u_upsw_host_model.set_dtr(1'b1);
    wt(5);
    chk("port_en", port_en, 1);
    chk("rx_ready", rx_ready, 0);
    wt(WK);
    chk("rx_ready", rx_ready, 1);
    chk("cts_n", cts_n, 0);
    wt(100);
    chk("port_en", port_en, 1);
    axi_wr(UPSW_CTRL_OFF, 32'h3, 4'hF);
    axi_rd(UPSW_CTRL_OFF);
    chk("mode", rd[1:0], UPSW_PS_DTR);
    u_upsw_host_model.set_dtr(1'b0);
    wt(6);
    chk("port_en", port_en, 0);
    axi_rd(UPSW_STAT_OFF);
    chk("stat", rd, 32'h50);
    $display("done dtr");
  endtask
  task automatic t_wake;
    axi_wr(UPSW_CTRL_OFF, 32'h1, 4'hF);
    wt(4);
    chk("port_en", port_en, 0);
    u_upsw_host_model.send_char(8'h55);
    chk("port_en", port_en, 1);
    rx_char <= 1'b1;
    @(posedge mclk);
    chk("wake_ok", rx_char_ok, 0);
    rx_char <= 1'b0;
    wt(WK);
    chk("rx_ready", rx_ready, 1);
    rx_char <= 1'b1;
    @(posedge mclk);
    chk("char_ok", rx_char_ok, 1);
    rx_char <= 1'b0;
    wt(350);
    chk("port_en", port_en, 1);
    wt(70);
    chk("port_en", port_en, 0);
    $display("done wake");
  endtask
  task automatic t_rts;
    u_upsw_host_model.set_rts(1'b0);
    axi_wr(UPSW_CTRL_OFF, 32'h2, 4'hF);
    wt(5);
    chk("drop", host_drop, 1);
    u_upsw_host_model.send_line(8'h41);
    chk("port_en", port_en, 0);
    usb_active <= 1'b1;
    wt(2);
    chk("dev_act", dev_active, 1);
    chk("port_en", port_en, 0);
    usb_active <= 1'b0;
    ce <= 1'b0;
    u_upsw_host_model.set_rts(1'b1);
    wt(5);
    chk("ce_hold", port_en, 0);
    chk("ce_awready", awready, 0);
    chk("ce_arready", arready, 0);
    ce <= 1'b1;
    wt(5);
    chk("port_en", port_en, 1);
    $display("done rts");
  endtask
  // Main sequence
  initial begin
    ce = 1'b1;
    resetn = 1'b0;
    wstrb = 4'hF;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_char, tx_pending, data_call, usb_active} = '0;
    wt(4);
    resetn <= 1'b1;
    t_reset();
    t_tmo();
    t_dtr();
    t_wake();
    t_rts();
    conclude();
  end
  // Watchdog
  initial begin
    wt(5000);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
